// >>> design/crm_top.sv
// Purpose: run/wait/stop/fallback mode control, reset sources, register file
// Assumes: mode requests come from logic on sys_clk_i; pll and pin levels are asynchronous
// Notes: one packed struct holds all state
`timescale 1ns/100ps
`default_nettype none
`include "crm_cfg.svh"
module crm_top
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic wait_req_i,
    input wire logic stop_req_i,
    input wire logic osc_loss_i,
    input wire logic quality_ok_i,
    input wire logic pll_lock_i,
    input wire logic pll_track_i,
    input wire logic por_i,
    input wire logic lvr_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic sys_rst_o,
    output logic osc_en_o,
    output logic sys_clk_en_o,
    output logic core_clk_en_o,
    output logic bus_clk_en_o,
    output logic use_pll_o,
    output logic quality_check_o,
    output logic fallback_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // decode and synchronised inputs
    // ----------------------------------------------------------------
    crm_pkg::crm_state_t s_q;
    crm_pkg::crm_state_t s_d;
    logic [3:0] idx;
    logic req;
    logic wr_go;
    logic [7:0] wd8;
    logic loss_s, qual_s, lock_s, track_s, por_s, lvr_s, pin_s;
    logic is_fb;
    logic sys_run;
    logic fb_go;
    logic loss_rst;
    logic [15:0] wd_lim;
    logic [15:0] tk_lim;
    logic wd_open;
    logic osc_tick;
    logic wd_run;
    logic tk_run;
    logic wd_to;
    logic pll_bad;
    logic trig;

    // byte address is four times the index, lane 0 carries the data
    assign idx = wb_adr_i[5:2];
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_go = req & wb_we_i & wb_sel_i[0] & s_q.ack & ~s_q.sys_rst;
    assign wd8 = wb_dat_i[7:0];
    // only second-stage flops are read
    assign {pin_s, lvr_s, por_s, track_s, lock_s, qual_s, loss_s} = s_q.s2;
    assign is_fb = (s_q.mode == crm_pkg::mode_fb);

    // mode-dependent clock gating
    assign sys_run = (s_q.mode == crm_pkg::mode_run) | is_fb
                   | ((s_q.mode == crm_pkg::mode_wait) & ~s_q.csel[`CRM_CS_SYSW]);
    assign osc_en_o = (s_q.mode != crm_pkg::mode_fstop);
    assign sys_clk_en_o = sys_run;
    assign core_clk_en_o = (s_q.mode == crm_pkg::mode_run) | is_fb
                         | ((s_q.mode == crm_pkg::mode_wait) & ~s_q.csel[`CRM_CS_COREW]);
    // half-rate enable off the selected source
    assign bus_clk_en_o = sys_run & s_q.div;
    assign use_pll_o = s_q.csel[`CRM_CS_PLL] | is_fb;
    assign quality_check_o = is_fb;
    assign fallback_o = is_fb;
    assign irq_o = s_q.irq;
    assign sys_rst_o = s_q.sys_rst;
    // open drain: only ever pulls low
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = (s_q.rst_cnt != 5'h00);
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = {24'h000000, s_q.rdat};

    // ----------------------------------------------------------------
    // mode, reset and counter conditions
    // ----------------------------------------------------------------
    // fallback only with both enables and a reported loss
    assign fb_go = s_q.lctl[`CRM_LC_MON] & s_q.lctl[`CRM_LC_FB] & loss_s
                 & ~is_fb & (s_q.mode != crm_pkg::mode_fstop);
    assign loss_rst = s_q.lctl[`CRM_LC_MON] & ~s_q.lctl[`CRM_LC_FB] & loss_s
                    & (s_q.mode != crm_pkg::mode_fstop);
    assign wd_lim = {s_q.wctl[2:0], 13'h1fff};
    assign tk_lim = {s_q.tctl[6:0], 9'h1ff};
    // with the window on, service only in the last quarter of the period
    assign wd_open = ~s_q.wctl[`CRM_WC_WIN] | (s_q.wd_cnt >= (wd_lim - {2'b00, wd_lim[15:2]}));
    assign osc_tick = osc_en_o & s_q.div;
    // counters freeze in full stop; pseudo stop follows its enables
    always_comb
    begin
        wd_run = 1'b0;
        tk_run = 1'b0;
        unique case (s_q.mode)
            crm_pkg::mode_run, crm_pkg::mode_fb:
            begin
                wd_run = 1'b1;
                tk_run = 1'b1;
            end
            crm_pkg::mode_wait:
            begin
                wd_run = ~s_q.csel[`CRM_CS_WDW];
                tk_run = ~s_q.csel[`CRM_CS_TICKW];
            end
            crm_pkg::mode_pstop:
            begin
                wd_run = s_q.lctl[`CRM_LC_PWD];
                tk_run = s_q.lctl[`CRM_LC_PTK];
            end
            default:
            begin
                wd_run = 1'b0;
                tk_run = 1'b0;
            end
        endcase
    end
    assign wd_to = wd_run & osc_tick & (s_q.wctl[2:0] != 3'h0) & (s_q.wd_cnt == wd_lim);
    // loop clock refused while lock (auto) or track (manual) is absent
    assign pll_bad = s_q.lctl[`CRM_LC_AUTO] ? ~lock_s : ~track_s;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic wd_bad;
        logic [7:0] stat;
        logic [7:0] rd;
        wd_bad = 1'b0;
        stat = {s_q.tick_f, s_q.por_f, s_q.lvr_f, s_q.lockc_f, lock_s & ~is_fb,
                track_s & ~is_fb, s_q.fbc_f, is_fb};
        rd = 8'h00;
        s_d = s_q;
        s_d.s1 = {~rst_pin_i, lvr_i, por_i, pll_track_i, pll_lock_i, quality_ok_i, osc_loss_i};
        s_d.s2 = s_q.s1;
        s_d.div = osc_en_o ? ~s_q.div : s_q.div;
        s_d.lock_prev = lock_s;

        // read mux, factory registers read zero
        unique case (idx)
            `CRM_IDX_LOOP_MULT: rd = s_q.mult;
            `CRM_IDX_REF_DIV: rd = s_q.refdiv;
            `CRM_IDX_STATUS: rd = stat;
            `CRM_IDX_IRQ_EN: rd = s_q.ie;
            `CRM_IDX_CLK_SEL: rd = s_q.csel;
            `CRM_IDX_LOOP_CTL: rd = s_q.lctl;
            `CRM_IDX_TICK_CTL: rd = s_q.tctl;
            `CRM_IDX_WD_CTL: rd = s_q.wctl;
            default: rd = 8'h00;
        endcase
        // one wait state: ack the cycle after the request is seen
        s_d.ack = req & ~s_q.ack;
        s_d.rdat = (req & ~s_q.ack & ~wb_we_i) ? rd : 8'h00;

        // register writes; clears come first so a same-cycle set wins
        if (wr_go)
        begin
            unique case (idx)
                `CRM_IDX_LOOP_MULT: if (!s_q.csel[`CRM_CS_PLL]) s_d.mult = wd8;
                `CRM_IDX_REF_DIV: if (!s_q.csel[`CRM_CS_PLL]) s_d.refdiv = wd8;
                `CRM_IDX_STATUS:
                begin
                    s_d.tick_f = s_q.tick_f & ~wd8[7];
                    s_d.por_f = s_q.por_f & ~wd8[6];
                    s_d.lvr_f = s_q.lvr_f & ~wd8[5];
                    s_d.lockc_f = s_q.lockc_f & ~wd8[4];
                    s_d.fbc_f = s_q.fbc_f & ~wd8[1];
                end
                `CRM_IDX_IRQ_EN: s_d.ie = wd8 & 8'h92;
                `CRM_IDX_CLK_SEL:
                begin
                    s_d.csel = wd8;
                    if (wd8[`CRM_CS_PLL] & pll_bad)
                        s_d.csel[`CRM_CS_PLL] = s_q.csel[`CRM_CS_PLL];
                end
                `CRM_IDX_LOOP_CTL:
                begin
                    s_d.lctl = wd8;
                    if (is_fb)
                        s_d.lctl[`CRM_LC_MON] = s_q.lctl[`CRM_LC_MON];
                end
                `CRM_IDX_TICK_CTL: s_d.tctl = wd8;
                `CRM_IDX_WD_CTL: s_d.wctl = wd8;
                `CRM_IDX_WD_SVC:
                begin
                    // arm key then clear key, both inside the window
                    if (s_q.wctl[2:0] != 3'h0)
                    begin
                        if (wd_open & (wd8 == `CRM_KEY_ARM))
                            s_d.wd_armed = 1'b1;
                        else if (wd_open & s_q.wd_armed & (wd8 == `CRM_KEY_CLR))
                        begin
                            s_d.wd_armed = 1'b0;
                            s_d.wd_cnt = 16'h0000;
                        end
                        else
                            wd_bad = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // mode sequencing
        unique case (s_q.mode)
            crm_pkg::mode_run:
            begin
                if (stop_req_i)
                begin
                    s_d.mode = s_q.csel[`CRM_CS_KEEP] ? crm_pkg::mode_pstop : crm_pkg::mode_fstop;
                    s_d.csel[`CRM_CS_PLL] = 1'b0;
                end
                else if (wait_req_i)
                begin
                    s_d.mode = crm_pkg::mode_wait;
                    if (s_q.csel[`CRM_CS_PLLW])
                        s_d.csel[`CRM_CS_PLL] = 1'b0;
                end
            end
            crm_pkg::mode_wait: if (!wait_req_i) s_d.mode = crm_pkg::mode_run;
            crm_pkg::mode_fstop, crm_pkg::mode_pstop: if (!stop_req_i) s_d.mode = crm_pkg::mode_run;
            crm_pkg::mode_fb: if (qual_s) s_d.mode = crm_pkg::mode_run;
            default: s_d.mode = crm_pkg::mode_run;
        endcase
        if (fb_go)
        begin
            s_d.mode = crm_pkg::mode_fb;
            s_d.csel[`CRM_CS_PLL] = 1'b0;
        end

        // watchdog and periodic tick; a wait-stop bit also clears its counter
        if ((s_q.mode == crm_pkg::mode_wait) & s_q.csel[`CRM_CS_WDW])
            s_d.wd_cnt = 16'h0000;
        else if (wd_run & osc_tick & (s_q.wctl[2:0] != 3'h0))
            s_d.wd_cnt = wd_to ? 16'h0000 : s_q.wd_cnt + 16'h0001;
        if ((s_q.mode == crm_pkg::mode_wait) & s_q.csel[`CRM_CS_TICKW])
            s_d.tk_cnt = 16'h0000;
        else if (tk_run & osc_tick & (s_q.tctl[6:0] != 7'h00))
            s_d.tk_cnt = (s_q.tk_cnt == tk_lim) ? 16'h0000 : s_q.tk_cnt + 16'h0001;

        // hardware sets, after the clears
        if (tk_run & osc_tick & (s_q.tctl[6:0] != 7'h00) & (s_q.tk_cnt == tk_lim))
            s_d.tick_f = 1'b1;
        if (lock_s != s_q.lock_prev)
            s_d.lockc_f = 1'b1;
        if (por_s)
            s_d.por_f = 1'b1;
        if (lvr_s)
            s_d.lvr_f = 1'b1;

        // internal reset sources stretch a low pulse on the pin
        trig = por_s | lvr_s | wd_to | wd_bad | loss_rst;
        if (trig)
            s_d.rst_cnt = 5'(`CRM_RST_PULSE_CYC);
        else if (s_q.rst_cnt != 5'h00)
            s_d.rst_cnt = s_q.rst_cnt - 5'h01;
        s_d.sys_rst = trig | (s_q.rst_cnt != 5'h00) | pin_s;
        if (s_q.sys_rst)
        begin
            // system reset re-initialises control, keeps the cause flags
            s_d.mode = crm_pkg::mode_run;
            s_d.mult = 8'h00;
            s_d.refdiv = 8'h00;
            s_d.ie = 8'h00;
            s_d.csel = 8'h00;
            s_d.lctl = `CRM_RST_LCTL;
            s_d.tctl = 8'h00;
            s_d.wctl = 8'h00;
            s_d.wd_cnt = 16'h0000;
            s_d.tk_cnt = 16'h0000;
            s_d.wd_armed = 1'b0;
        end
        if ((s_d.mode == crm_pkg::mode_fb) != is_fb) // after the reset override, so a reset out of fallback counts
            s_d.fbc_f = 1'b1;
        s_d.irq = |(stat & s_q.ie);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // async reset loads constants only
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.mode <= crm_pkg::mode_run;
            s_q.lctl <= `CRM_RST_LCTL;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_full_stop;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s_q.mode == crm_pkg::mode_run) && stop_req_i && !s_q.csel[`CRM_CS_KEEP] && !fb_go && !s_q.sys_rst
        |=> !osc_en_o && !sys_clk_en_o ##1 ($stable(s_q.wd_cnt) || s_q.sys_rst);
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("full stop left oscillator or counter running");
    property p_pseudo_stop;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s_q.mode == crm_pkg::mode_run) && stop_req_i && s_q.csel[`CRM_CS_KEEP] && !fb_go && !s_q.sys_rst
        |=> osc_en_o && !sys_clk_en_o && !core_clk_en_o;
    endproperty
    a_pseudo_stop: assert property (p_pseudo_stop) else $error("pseudo stop clock gating wrong");
    property p_pstop_frozen;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s_q.mode == crm_pkg::mode_pstop) && !s_q.lctl[`CRM_LC_PTK] && !s_q.sys_rst && !fb_go
        |=> (s_q.tk_cnt == $past(s_q.tk_cnt)) || s_q.sys_rst;
    endproperty
    a_pstop_frozen: assert property (p_pstop_frozen) else $error("tick counter moved in pseudo stop");
    property p_fb_entry;
        @(posedge sys_clk_i) disable iff (rst_i)
        fb_go && !s_q.sys_rst |=> fallback_o && quality_check_o && !s_q.csel[`CRM_CS_PLL];
    endproperty
    a_fb_entry: assert property (p_fb_entry) else $error("fallback not entered on clock loss");
    property p_fb_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        is_fb && !qual_s && !s_q.sys_rst |=> is_fb;
    endproperty
    a_fb_hold: assert property (p_fb_hold) else $error("fallback left before quality check");
    property p_pin_pulse;
        @(posedge sys_clk_i) disable iff (rst_i)
        trig |=> (rst_pin_oe_o && sys_rst_o) [*8];
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("reset pin pulse too short");
    property p_lock_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        (lock_s != s_q.lock_prev) && s_q.ie[4] |=> s_q.lockc_f ##1 irq_o;
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock change not flagged");
    property p_fb_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        $changed(is_fb) |-> s_q.fbc_f;
    endproperty
    a_fb_flag: assert property (p_fb_flag) else $error("fallback change flag not set");
    property p_pll_guard;
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_go && (idx == `CRM_IDX_CLK_SEL) && wd8[`CRM_CS_PLL] && pll_bad && !s_q.csel[`CRM_CS_PLL]
        |=> !s_q.csel[`CRM_CS_PLL];
    endproperty
    a_pll_guard: assert property (p_pll_guard) else $error("loop select taken while unstable");
    property p_half_rate;
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_clk_en_o && sys_clk_en_o |=> !bus_clk_en_o ##1 (bus_clk_en_o || !sys_clk_en_o);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("bus enable not half rate");
    property p_ack;
        @(posedge sys_clk_i) disable iff (rst_i)
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule : crm_top
`default_nettype wire

// >>> pkg/crm_cfg.svh
// Purpose: offsets, field positions, reset values and timing for the clock/reset mode control
// Assumes: 40 MHz system clock, byte registers on a 32-bit classic wishbone port
// Notes: register byte address is four times the index below
`ifndef CRM_CFG_SVH
`define CRM_CFG_SVH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CRM_IDX_LOOP_MULT 4'h0
`define CRM_IDX_REF_DIV 4'h1
`define CRM_IDX_FACT_FLAGS 4'h2
`define CRM_IDX_STATUS 4'h3
`define CRM_IDX_IRQ_EN 4'h4
`define CRM_IDX_CLK_SEL 4'h5
`define CRM_IDX_LOOP_CTL 4'h6
`define CRM_IDX_TICK_CTL 4'h7
`define CRM_IDX_WD_CTL 4'h8
`define CRM_IDX_FACT_BYP 4'h9
`define CRM_IDX_FACT_CTL 4'ha
`define CRM_IDX_WD_SVC 4'hb
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CRM_CS_PLL 7
`define CRM_CS_KEEP 6
`define CRM_CS_SYSW 5
`define CRM_CS_PLLW 3
`define CRM_CS_COREW 2
`define CRM_CS_TICKW 1
`define CRM_CS_WDW 0
`define CRM_LC_MON 7
`define CRM_LC_AUTO 5
`define CRM_LC_PWD 2
`define CRM_LC_PTK 1
`define CRM_LC_FB 0
`define CRM_WC_WIN 7
// ----------------------------------------------------------------
// reset values, keys, timing
// ----------------------------------------------------------------
`define CRM_RST_LCTL 8'ha1
`define CRM_KEY_ARM 8'h55
`define CRM_KEY_CLR 8'haa
`define CRM_CLK_NS 25
`define CRM_RST_PULSE_NS 400
`define CRM_RST_PULSE_CYC ((`CRM_RST_PULSE_NS + `CRM_CLK_NS - 1) / `CRM_CLK_NS)
`endif

// >>> pkg/crm_pkg.sv
// Purpose: types for the clock/reset mode control
// Assumes: constants live in crm_cfg.svh
// Notes: whole module state is one packed struct
package crm_pkg;
    typedef enum logic [4:0]
    {
        mode_run = 5'b00001,
        mode_wait = 5'b00010,
        mode_fstop = 5'b00100,
        mode_pstop = 5'b01000,
        mode_fb = 5'b10000
    } crm_mode_t;

    typedef struct packed {
        crm_mode_t mode;
        logic [6:0] s1;
        logic [6:0] s2;
        logic [7:0] mult;
        logic [7:0] refdiv;
        logic [7:0] ie;
        logic [7:0] csel;
        logic [7:0] lctl;
        logic [7:0] tctl;
        logic [7:0] wctl;
        logic tick_f;
        logic por_f;
        logic lvr_f;
        logic lockc_f;
        logic fbc_f;
        logic lock_prev;
        logic wd_armed;
        logic [15:0] wd_cnt;
        logic [15:0] tk_cnt;
        logic [4:0] rst_cnt;
        logic sys_rst;
        logic div;
        logic irq;
        logic ack;
        logic [7:0] rdat;
    } crm_state_t;
endpackage : crm_pkg

// >>> test/clock_reset_mode_control_tb.sv
// Purpose: self-checking bench for the clock/reset mode control
// Assumes: 40 MHz clock, one-cycle registered ack on the register port
// Notes: synchroniser latency is fixed, so short fixed waits follow async inputs
`timescale 1ns/100ps
`default_nettype none
`include "crm_cfg.svh"
module clock_reset_mode_control_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pin;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic wreq = 1'b0, sreq = 1'b0, loss = 1'b0, qok = 1'b0, lock = 1'b0, por = 1'b0, ext = 1'b0;
    logic trk = 1'b0, lvr = 1'b0;
    logic pval, poe, srst, osc, sclk, cclk, bclk, upll, qchk, fb, irq;
    int fail_count = 0, check_count = 0, cycles = 0;
    always #12.5 clk = ~clk;
    crm_top u_dut (.sys_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wait_req_i(wreq), .stop_req_i(sreq), .osc_loss_i(loss), .quality_ok_i(qok),
        .pll_lock_i(lock), .pll_track_i(trk), .por_i(por), .lvr_i(lvr), .rst_pin_i(pin),
        .rst_pin_o(pval), .rst_pin_oe_o(poe), .sys_rst_o(srst), .osc_en_o(osc),
        .sys_clk_en_o(sclk), .core_clk_en_o(cclk), .bus_clk_en_o(bclk), .use_pll_o(upll),
        .quality_check_o(qchk), .fallback_o(fb), .irq_o(irq));
    crm_pin_model u_pin (.ext_low_i(ext), .dev_val_i(pval), .dev_oe_i(poe), .pin_o(pin));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks=%0d fails=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one classic cycle; held until ack is sampled high, no latency assumed
    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        wb(0, `CRM_IDX_LOOP_CTL, 8'h00);
        check(r, {24'h0, `CRM_RST_LCTL});
        wb(1, `CRM_IDX_IRQ_EN, 8'hff);
        wb(0, `CRM_IDX_IRQ_EN, 8'h00);
        check(r, 32'h92);
        wb(1, `CRM_IDX_FACT_FLAGS, 8'hff);
        wb(0, `CRM_IDX_FACT_FLAGS, 8'h00);
        check(r, 32'h0);
        wb(1, 4'hc, 8'h5a);
        wb(0, 4'hc, 8'h00);
        check(r, 32'h0);
        wb(1, `CRM_IDX_IRQ_EN, 8'h00);
    endtask : t_regs
    task automatic t_modes(input logic [7:0] cs, input logic w, input logic [2:0] exp);
        wb(1, `CRM_IDX_CLK_SEL, cs);
        wreq <= w;
        sreq <= !w;
        tick(3);
        check({osc, sclk, cclk}, exp);
        wreq <= 1'b0;
        sreq <= 1'b0;
        tick(3);
        check({osc, sclk, cclk}, 3'h7);
    endtask : t_modes
    task automatic t_fallback();
        wb(1, `CRM_IDX_LOOP_CTL, 8'h20);
        loss <= 1'b1;
        tick(6);
        check(fb, 1'b0);
        loss <= 1'b0;
        tick(6);
        wb(1, `CRM_IDX_LOOP_CTL, 8'ha1);
        loss <= 1'b1;
        tick(6);
        check({fb, qchk}, 2'h3);
        wb(0, `CRM_IDX_STATUS, 8'h00);
        check(r & 32'h3, 32'h3);
        loss <= 1'b0;
        tick(8);
        check(fb, 1'b1);
        qok <= 1'b1;
        tick(6);
        check(fb, 1'b0);
        qok <= 1'b0;
    endtask : t_fallback
    task automatic t_lock();
        wb(1, `CRM_IDX_CLK_SEL, 8'h80);
        wb(0, `CRM_IDX_CLK_SEL, 8'h00);
        check(r, 32'h0);
        wb(1, `CRM_IDX_IRQ_EN, 8'h10);
        lock <= 1'b1;
        tick(6);
        wb(0, `CRM_IDX_STATUS, 8'h00);
        check(r & 32'h10, 32'h10);
        check(irq, 1'b1);
        wb(1, `CRM_IDX_STATUS, 8'h12);
        tick(2);
        check(irq, 1'b0);
        wb(1, `CRM_IDX_CLK_SEL, 8'h80);
        tick(2);
        check(upll, 1'b1);
        wb(1, `CRM_IDX_CLK_SEL, 8'h00);
        tick(2);
        check(upll, 1'b0);
        // manual mode: a locked loop that is not tracking is still refused
        wb(1, `CRM_IDX_LOOP_CTL, 8'h81);
        wb(1, `CRM_IDX_CLK_SEL, 8'h80);
        tick(2);
        check(upll, 1'b0);
        trk <= 1'b1;
        tick(6);
        wb(1, `CRM_IDX_CLK_SEL, 8'h80);
        tick(2);
        check(upll, 1'b1);
        // multiplier is write-locked while the loop clock is selected
        wb(1, `CRM_IDX_LOOP_MULT, 8'h33);
        wb(0, `CRM_IDX_LOOP_MULT, 8'h00);
        check(r, 32'h0);
        wb(1, `CRM_IDX_CLK_SEL, 8'h00);
        tick(2);
        check(upll, 1'b0);
        wb(1, `CRM_IDX_LOOP_MULT, 8'h33);
        wb(0, `CRM_IDX_LOOP_MULT, 8'h00);
        check(r, 32'h33);
    endtask : t_lock
    // software gives the tick a nonzero rate; period is 1024 half-rate counts
    task automatic t_tick();
        wb(1, `CRM_IDX_IRQ_EN, 8'h80);
        wb(1, `CRM_IDX_TICK_CTL, 8'h01);
        tick(2000);
        check(irq, 1'b0);
        tick(60);
        check(irq, 1'b1);
        wb(0, `CRM_IDX_STATUS, 8'h00);
        check(r & 32'h80, 32'h80);
        wb(1, `CRM_IDX_TICK_CTL, 8'h00);
        wb(1, `CRM_IDX_IRQ_EN, 8'h00);
    endtask : t_tick
    task automatic t_bus_clk();
        logic b0;
        tick(1);
        b0 = bclk;
        tick(1);
        check(b0 ^ bclk, 1'b1);
    endtask : t_bus_clk
    task automatic t_reset();
        ext <= 1'b1;
        tick(6);
        check(srst, 1'b1);
        ext <= 1'b0;
        tick(40);
        check(srst, 1'b0);
        por <= 1'b1;
        tick(2);
        por <= 1'b0;
        tick(4);
        check({srst, poe, pin}, 3'h6);
        tick(40);
        wb(0, `CRM_IDX_STATUS, 8'h00);
        check(r & 32'h40, 32'h40);
        lvr <= 1'b1;
        tick(2);
        lvr <= 1'b0;
        tick(4);
        check({srst, poe}, 2'h3);
        tick(40);
        wb(0, `CRM_IDX_STATUS, 8'h00);
        check(r & 32'h20, 32'h20);
        // service without window is taken; an early arm inside a window resets
        wb(1, `CRM_IDX_WD_CTL, 8'h01);
        wb(1, `CRM_IDX_WD_SVC, `CRM_KEY_ARM);
        wb(1, `CRM_IDX_WD_SVC, `CRM_KEY_CLR);
        tick(2);
        check(srst, 1'b0);
        wb(1, `CRM_IDX_WD_CTL, 8'h81);
        wb(1, `CRM_IDX_WD_SVC, `CRM_KEY_ARM);
        tick(2);
        check({srst, poe}, 2'h3);
        tick(40);
        check(srst, 1'b0);
    endtask : t_reset
    // ------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        tick(12);
        rst <= 1'b0;
        t_regs();
        t_bus_clk();
        t_modes(8'h00, 1'b0, 3'h0);
        t_modes(8'h40, 1'b0, 3'h4);
        t_modes(8'h24, 1'b1, 3'h4);
        t_modes(8'h00, 1'b1, 3'h7);
        t_fallback();
        t_lock();
        t_tick();
        t_reset();
        stop_test();
    end
endmodule : clock_reset_mode_control_tb
`default_nettype wire

// >>> test/crm_pin_model.sv
// Purpose: board side of the active-low reset pin
// Assumes: pull-up on the pin, open-drain device output
// Notes: bench asks for an external low through ext_low_i
`timescale 1ns/100ps
`default_nettype none
module crm_pin_model
(
    input wire logic ext_low_i,
    input wire logic dev_val_i,
    input wire logic dev_oe_i,
    output logic pin_o
);
    // wired-and of both pull-downs; the pull-up wins when nobody pulls
    assign pin_o = !((dev_oe_i && !dev_val_i) || ext_low_i);
endmodule : crm_pin_model
`default_nettype wire
